// ==== hdl/irq_regs_pkg.sv ====
// Purpose: constants shared by the interrupt command and status register block
// Assumes: classic Wishbone slave, 32-bit data, byte addresses
// Notes:   offsets are byte addresses of aligned words
package irq_regs_pkg;
	// ----------------------------------------------------------------
	// register offsets
	// ----------------------------------------------------------------
	localparam logic [8:0] normal_vector_off   = 9'h100;
	localparam logic [8:0] fast_vector_off     = 9'h104;
	localparam logic [8:0] source_number_off   = 9'h108;
	localparam logic [8:0] pending_off         = 9'h10c;
	localparam logic [8:0] enabled_off         = 9'h110;
	localparam logic [8:0] core_line_off       = 9'h114;
	localparam logic [8:0] enable_cmd_off      = 9'h120;
	localparam logic [8:0] disable_cmd_off     = 9'h124;
	localparam logic [8:0] clear_cmd_off       = 9'h128;
	localparam logic [8:0] set_cmd_off         = 9'h12c;
	localparam logic [8:0] end_service_off     = 9'h130;
	localparam logic [8:0] spurious_off        = 9'h134;
	localparam logic [8:0] debug_off           = 9'h138;
	localparam logic [8:0] fast_en_cmd_off     = 9'h140;
	localparam logic [8:0] fast_dis_cmd_off    = 9'h144;
	localparam logic [8:0] fast_status_off     = 9'h148;
	localparam logic [8:0] evt_status_off      = 9'h150;
	localparam logic [8:0] evt_clear_off       = 9'h154;
	localparam logic [8:0] evt_enable_off      = 9'h158;
	// ----------------------------------------------------------------
	// fields and reset values
	// ----------------------------------------------------------------
	localparam int          protection_bit     = 0;
	localparam int          line_hold_bit      = 1;
	localparam int          fast_line_bit      = 0;
	localparam int          normal_line_bit    = 1;
	localparam int          source_number_w    = 5;
	localparam int          evt_eoi_bit        = 0;
	localparam int          evt_set_bit        = 1;
	localparam logic [31:0] word_reset         = 32'h0000_0000;
	localparam logic [31:0] fast_route_mask    = 32'hffff_fffe;
	localparam logic [2:0]  evt_reset          = 3'h0;
endpackage

// ==== hdl/wb_req_if.sv ====
// Purpose: decoded register request passed from bus slave to core
// Assumes: one request per acknowledged bus cycle
// Notes:   wr and rd are one-cycle strobes
`timescale 1ns/1ps
interface wb_req_if;
	logic        wr;
	logic        rd;
	logic [8:0]  addr;
	logic [31:0] wdata;
	logic [3:0]  sel;
	modport slave (output wr, output rd, output addr, output wdata, output sel);
	modport core  (input wr, input rd, input addr, input wdata, input sel);
endinterface

// ==== hdl/wb_slave_front.sv ====
// Purpose: classic Wishbone front end, one request per bus cycle
// Assumes: master holds request until ack is seen
// Notes:   ack comes one edge after the request appears, then drops
`timescale 1ns/1ps
module wb_slave_front (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        cyc_i,
	input  wire logic        stb_i,
	input  wire logic        we_i,
	input  wire logic [31:0] adr_i,
	input  wire logic [31:0] dat_i,
	input  wire logic [3:0]  sel_i,
	output logic             ack_o,
	wb_req_if.slave          req
);
	logic ack_reg;
	wire  start = cyc_i & stb_i & ~ack_reg;

	// ----------------------------------------------------------------
	// request strobes
	// ----------------------------------------------------------------
	// strobe only in the cycle before ack, so each bus cycle acts once
	assign req.wr    = start & we_i;
	assign req.rd    = start & ~we_i;
	assign req.addr  = adr_i[8:0];
	assign req.wdata = dat_i;
	assign req.sel   = sel_i;
	assign ack_o     = ack_reg;

	// ack one cycle after start, dropped the cycle after
	always_ff @(posedge clk_i) begin
		if (rst_i) ack_reg <= 1'b0;
		else       ack_reg <= start;
	end
endmodule

// ==== hdl/irq_cmd_status.sv ====
// Purpose: command and status registers of a vectored interrupt controller
// Assumes: priority logic outside supplies current source and request levels
// Notes:   request lines to the core are active low and registered
`timescale 1ns/1ps
module irq_cmd_status (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// wishbone slave
	input  wire logic        cyc_i,
	input  wire logic        stb_i,
	input  wire logic        we_i,
	input  wire logic [31:0] adr_i,
	input  wire logic [31:0] dat_i,
	input  wire logic [3:0]  sel_i,
	output logic [31:0]      dat_o,
	output logic             ack_o,
	// priority and vectoring logic
	input  wire logic [31:0] source_level_i,
	input  wire logic [4:0]  current_source_number_i,
	input  wire logic        current_valid_i,
	input  wire logic        fast_current_i,
	input  wire logic        normal_request_i,
	input  wire logic        fast_request_i,
	input  wire logic [31:0] current_vector_i,
	input  wire logic [31:0] fast_vector_i,
	output logic [31:0]      pending_o,
	output logic [31:0]      enabled_o,
	output logic [31:0]      fast_route_o,
	output logic             end_of_service_o,
	output logic             normal_vector_read_o,
	output logic             fast_vector_read_o,
	output logic             protection_select_o,
	// core request lines
	output logic             normal_request_line_n_o,
	output logic             fast_request_line_n_o,
	// block interrupt
	output logic             irq_o
);
	wb_req_if req ();
	logic        wb_ack;

	logic [31:0] pending_reg;
	logic [31:0] pending_next;
	logic [31:0] enabled_reg;
	logic [31:0] enabled_next;
	logic [31:0] fast_route_reg;
	logic [31:0] fast_route_next;
	logic [31:0] spurious_reg;
	logic [1:0]  debug_reg;
	logic        normal_n_reg;
	logic        fast_n_reg;
	logic [31:0] rdata_reg;
	logic        eos_reg;
	logic        nvr_reg;
	logic        fvr_reg;
	logic [2:0]  evt_status_reg;
	logic [2:0]  evt_enable_reg;
	logic        irq_reg;

	// ----------------------------------------------------------------
	// bus front end
	// ----------------------------------------------------------------
	wb_slave_front front (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.cyc_i (cyc_i),
		.stb_i (stb_i),
		.we_i  (we_i),
		.adr_i (adr_i),
		.dat_i (dat_i),
		.sel_i (sel_i),
		.ack_o (wb_ack),
		.req   (req)
	);

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	// byte lanes that sel marks, for partial writes to stored words
	function automatic logic [31:0] lane_mask(input logic [3:0] sel);
		lane_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
	endfunction

	function automatic logic hit_write(input logic wr, input logic [8:0] a,
		input logic [8:0] off);
		hit_write = wr & (a == off);
	endfunction

	// ----------------------------------------------------------------
	// write and vector read decode
	// ----------------------------------------------------------------
	wire [31:0] wmask    = lane_mask(req.sel);
	wire [31:0] wbits    = req.wdata & wmask;
	wire        wr_en    = hit_write(req.wr, req.addr, irq_regs_pkg::enable_cmd_off);
	wire        wr_dis   = hit_write(req.wr, req.addr, irq_regs_pkg::disable_cmd_off);
	wire        wr_clr   = hit_write(req.wr, req.addr, irq_regs_pkg::clear_cmd_off);
	wire        wr_set   = hit_write(req.wr, req.addr, irq_regs_pkg::set_cmd_off);
	wire        wr_eos   = hit_write(req.wr, req.addr, irq_regs_pkg::end_service_off);
	wire        wr_spu   = hit_write(req.wr, req.addr, irq_regs_pkg::spurious_off);
	wire        wr_dbg   = hit_write(req.wr, req.addr, irq_regs_pkg::debug_off);
	wire        wr_ffen  = hit_write(req.wr, req.addr, irq_regs_pkg::fast_en_cmd_off);
	wire        wr_ffdis = hit_write(req.wr, req.addr, irq_regs_pkg::fast_dis_cmd_off);
	wire        wr_eclr  = hit_write(req.wr, req.addr, irq_regs_pkg::evt_clear_off);
	wire        wr_een   = hit_write(req.wr, req.addr, irq_regs_pkg::evt_enable_off);
	wire        rd_nvec  = hit_write(req.rd, req.addr, irq_regs_pkg::normal_vector_off);
	wire        rd_fvec  = hit_write(req.rd, req.addr, irq_regs_pkg::fast_vector_off);

	// ----------------------------------------------------------------
	// per-source state next values
	// ----------------------------------------------------------------
	// a command bit of zero leaves its source alone
	assign enabled_next = wr_en  ? (enabled_reg | wbits)  :
	                      wr_dis ? (enabled_reg & ~wbits) :
	                      enabled_reg;
	// a source level arriving with a clear keeps the bit set
	assign pending_next = ((wr_clr ? (pending_reg & ~wbits) : pending_reg)
	                      | (wr_set ? wbits : 32'h0000_0000)
	                      | source_level_i);
	// bit 0 is the fast source itself, so it can never be forced
	assign fast_route_next = wr_ffen ?
	                         (fast_route_reg | (wbits & irq_regs_pkg::fast_route_mask)) :
	                         wr_ffdis ? (fast_route_reg & ~wbits) :
	                         fast_route_reg;

	// ----------------------------------------------------------------
	// read mux
	// ----------------------------------------------------------------
	// no current source means a spurious interrupt, so the spurious word answers
	wire [31:0] nvec_word = current_valid_i ? current_vector_i : spurious_reg;
	wire [31:0] fvec_word = fast_current_i  ? fast_vector_i    : spurious_reg;
	wire [31:0] core_word = {30'h0000_0000, ~normal_n_reg, ~fast_n_reg};
	wire [31:0] num_word  = {27'h000_0000, current_source_number_i};
	logic [31:0] rmux;
	always_comb begin
		case (req.addr)
			irq_regs_pkg::normal_vector_off: rmux = nvec_word;
			irq_regs_pkg::fast_vector_off:   rmux = fvec_word;
			irq_regs_pkg::source_number_off: rmux = num_word;
			irq_regs_pkg::pending_off:       rmux = pending_reg;
			irq_regs_pkg::enabled_off:       rmux = enabled_reg;
			irq_regs_pkg::core_line_off:     rmux = core_word;
			irq_regs_pkg::spurious_off:      rmux = spurious_reg;
			irq_regs_pkg::debug_off:         rmux = {30'h0000_0000, debug_reg};
			irq_regs_pkg::fast_status_off:   rmux = fast_route_reg;
			irq_regs_pkg::evt_status_off:    rmux = {29'h0000_0000, evt_status_reg};
			irq_regs_pkg::evt_enable_off:    rmux = {29'h0000_0000, evt_enable_reg};
			default:                         rmux = 32'h0000_0000;
		endcase
	end

	// ----------------------------------------------------------------
	// per-source registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			enabled_reg    <= irq_regs_pkg::word_reset;
			pending_reg    <= irq_regs_pkg::word_reset;
			fast_route_reg <= irq_regs_pkg::word_reset;
		end else begin
			enabled_reg    <= enabled_next;
			pending_reg    <= pending_next;
			fast_route_reg <= fast_route_next;
		end
	end

	// ----------------------------------------------------------------
	// configuration registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			spurious_reg <= irq_regs_pkg::word_reset;
			debug_reg    <= 2'h0;
		end else begin
			if (wr_spu)
				spurious_reg <= (spurious_reg & ~wmask) | wbits;
			if (wr_dbg & req.sel[0])
				debug_reg <= req.wdata[1:0];
		end
	end

	// ----------------------------------------------------------------
	// core request lines
	// ----------------------------------------------------------------
	// line hold overrides everything, so a debugger can stop the core cleanly
	wire hold = debug_reg[irq_regs_pkg::line_hold_bit];
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			normal_n_reg <= 1'b1;
			fast_n_reg   <= 1'b1;
		end else begin
			normal_n_reg <= ~(normal_request_i & ~hold);
			fast_n_reg   <= ~(fast_request_i & ~hold);
		end
	end

	// ----------------------------------------------------------------
	// bus answer and strobes
	// ----------------------------------------------------------------
	// data and strobes load on the taking edge, the same edge the front end raises ack,
	// so all of them stand in the one ack cycle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rdata_reg <= 32'h0000_0000;
			eos_reg   <= 1'b0;
			nvr_reg   <= 1'b0;
			fvr_reg   <= 1'b0;
		end else begin
			rdata_reg <= req.rd ? rmux : 32'h0000_0000;
			eos_reg   <= wr_eos;
			nvr_reg   <= rd_nvec;
			fvr_reg   <= rd_fvec;
		end
	end

	// ----------------------------------------------------------------
	// block interrupt
	// ----------------------------------------------------------------
	// event 0 end of service, 1 pending set by software, 2 mask change
	wire [2:0] evt_in = {wr_en | wr_dis, wr_set, wr_eos};
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			evt_status_reg <= irq_regs_pkg::evt_reset;
			evt_enable_reg <= irq_regs_pkg::evt_reset;
			irq_reg        <= 1'b0;
		end else begin
			// new event wins over a clear in the same cycle
			evt_status_reg <= (evt_status_reg & ~(wr_eclr ? req.wdata[2:0] : 3'h0))
			                  | evt_in;
			if (wr_een)
				evt_enable_reg <= req.wdata[2:0];
			irq_reg <= |(evt_status_reg & evt_enable_reg);
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign dat_o                   = rdata_reg;
	assign ack_o                   = wb_ack;
	assign pending_o               = pending_reg;
	assign enabled_o               = enabled_reg;
	assign fast_route_o            = fast_route_reg;
	assign end_of_service_o        = eos_reg;
	assign normal_vector_read_o    = nvr_reg;
	assign fast_vector_read_o      = fvr_reg;
	assign protection_select_o     = debug_reg[irq_regs_pkg::protection_bit];
	assign normal_request_line_n_o = normal_n_reg;
	assign fast_request_line_n_o   = fast_n_reg;
	assign irq_o                   = irq_reg;
endmodule

// ==== testbench/irq_cmd_status_asserts.sv ====
// Purpose: port checker for irq_cmd_status
// Assumes: one clock, sync reset, whole-word writes checked
// Notes:   bound to the top module below
`timescale 1ns/1ps
module irq_cmd_status_asserts (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        cyc_i,
	input  wire logic        stb_i,
	input  wire logic        we_i,
	input  wire logic [31:0] adr_i,
	input  wire logic [31:0] dat_i,
	input  wire logic [3:0]  sel_i,
	input  wire logic [31:0] dat_o,
	input  wire logic        ack_o,
	input  wire logic        normal_request_i,
	input  wire logic        fast_request_i,
	input  wire logic [31:0] pending_o,
	input  wire logic [31:0] enabled_o,
	input  wire logic [31:0] fast_route_o,
	input  wire logic        end_of_service_o,
	input  wire logic        normal_vector_read_o,
	input  wire logic        fast_vector_read_o,
	input  wire logic        normal_request_line_n_o,
	input  wire logic        fast_request_line_n_o
);
	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	wire       [8:0] a    = adr_i[8:0];
	wire             take = cyc_i && stb_i && we_i && !ack_o && sel_i == 4'hf;
	logic            hold_q;
	// line hold mirror, only full-word writes so byte lanes cannot mislead it
	always_ff @(posedge clk_i) begin
		if (rst_i)
			hold_q <= 1'b0;
		else if (take && a == irq_regs_pkg::debug_off)
			hold_q <= dat_i[1];
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	sequence s_wr(off);
		take && a == off;
	endsequence
	// ------------------------------------------------------------
	// properties
	// ------------------------------------------------------------
	property p_ack_pulse;
		ack_o |=> !ack_o;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
	property p_ack_time;
		$rose(stb_i) && cyc_i |=> ack_o;
	endproperty
	a_ack_time: assert property (p_ack_time) else $error("ack late");
	property p_dat_idle;
		!ack_o |-> dat_o == 32'h0;
	endproperty
	a_dat_idle: assert property (p_dat_idle) else $error("read data outside ack");
	property p_enable;
		s_wr(irq_regs_pkg::enable_cmd_off) |-> ##2 (enabled_o & $past(dat_i, 2)) == $past(dat_i, 2);
	endproperty
	a_enable: assert property (p_enable) else $error("enable lost");
	property p_disable;
		s_wr(irq_regs_pkg::disable_cmd_off) |-> ##2 (enabled_o & $past(dat_i, 2)) == 32'h0;
	endproperty
	a_disable: assert property (p_disable) else $error("disable lost");
	property p_set;
		s_wr(irq_regs_pkg::set_cmd_off) |-> ##2 (pending_o & $past(dat_i, 2)) == $past(dat_i, 2);
	endproperty
	a_set: assert property (p_set) else $error("set lost");
	property p_fast;
		s_wr(irq_regs_pkg::fast_en_cmd_off) |-> ##2 fast_route_o
			== ($past(fast_route_o, 2) | ($past(dat_i, 2) & irq_regs_pkg::fast_route_mask));
	endproperty
	a_fast: assert property (p_fast) else $error("fast route wrong");
	property p_eos;
		end_of_service_o == (ack_o && cyc_i && we_i && a == irq_regs_pkg::end_service_off);
	endproperty
	a_eos: assert property (p_eos) else $error("end pulse wrong");
	property p_nvr;
		normal_vector_read_o == (ack_o && cyc_i && !we_i && a == irq_regs_pkg::normal_vector_off);
	endproperty
	a_nvr: assert property (p_nvr) else $error("normal vector read pulse wrong");
	property p_fvr;
		fast_vector_read_o == (ack_o && cyc_i && !we_i && a == irq_regs_pkg::fast_vector_off);
	endproperty
	a_fvr: assert property (p_fvr) else $error("fast vector read pulse wrong");
	property p_hold;
		$past(hold_q) |-> normal_request_line_n_o && fast_request_line_n_o;
	endproperty
	a_hold: assert property (p_hold) else $error("lines not held");
	property p_follow;
		!$past(hold_q) |-> normal_request_line_n_o == !$past(normal_request_i)
			&& fast_request_line_n_o == !$past(fast_request_i);
	endproperty
	a_follow: assert property (p_follow) else $error("line lag wrong");
endmodule
bind irq_cmd_status irq_cmd_status_asserts chk (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i,
	.adr_i, .dat_i, .sel_i, .dat_o, .ack_o, .normal_request_i, .fast_request_i, .pending_o,
	.enabled_o, .fast_route_o, .end_of_service_o, .normal_vector_read_o,
	.fast_vector_read_o, .normal_request_line_n_o, .fast_request_line_n_o);

// ==== testbench/core_model.sv ====
// Purpose: processor core side of the two request lines
// Assumes: core samples its lines on the system clock
// Notes:   reports what it saw as active-high flags
`timescale 1ns/1ps
module core_model (
	input  wire logic clk_i,
	input  wire logic normal_request_line_n_i,
	input  wire logic fast_request_line_n_i,
	output logic      normal_seen_o,
	output logic      fast_seen_o
);
	// one flop of lag, as a real core input stage would add
	always_ff @(posedge clk_i) begin
		normal_seen_o <= !normal_request_line_n_i;
		fast_seen_o   <= !fast_request_line_n_i;
	end
endmodule

// ==== testbench/tb.sv ====
// Purpose: register-level bench for irq_cmd_status
// Assumes: classic Wishbone, full-word accesses
// Notes:   core_model watches the request lines
`timescale 1ns/1ps
module tb;
	logic        clk_i                   = 1'b0;
	logic        rst_i                   = 1'b1;
	logic        cyc_i                   = 1'b0;
	logic        stb_i                   = 1'b0;
	logic        we_i                    = 1'b0;
	logic [31:0] adr_i                   = 32'h0;
	logic [31:0] dat_i                   = 32'h0;
	logic [31:0] source_level_i          = 32'h0;
	logic [4:0]  current_source_number_i = 5'h0;
	logic        current_valid_i         = 1'b0;
	logic        fast_current_i          = 1'b0;
	logic        normal_request_i        = 1'b0;
	logic        fast_request_i          = 1'b0;
	logic [31:0] current_vector_i        = 32'h0;
	logic [31:0] fast_vector_i           = 32'h0;
	logic [31:0] dat_o;
	logic        ack_o;
	logic        irq_o;
	logic        protection_select_o;
	logic        nline_n;
	logic        fline_n;
	logic        nseen;
	logic        fseen;
	int          error_cnt               = 0;
	int          tests_run               = 0;
	irq_cmd_status dut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .dat_i,
		.sel_i(4'hf), .dat_o, .ack_o, .source_level_i, .current_source_number_i,
		.current_valid_i, .fast_current_i, .normal_request_i, .fast_request_i,
		.current_vector_i, .fast_vector_i, .pending_o(), .enabled_o(), .fast_route_o(),
		.end_of_service_o(), .normal_vector_read_o(), .fast_vector_read_o(),
		.protection_select_o, .normal_request_line_n_o(nline_n),
		.fast_request_line_n_o(fline_n), .irq_o);
	core_model core (.clk_i, .normal_request_line_n_i(nline_n),
		.fast_request_line_n_i(fline_n), .normal_seen_o(nseen), .fast_seen_o(fseen));
	// ------------------------------------------------------------
	// bus tasks and checks
	// ------------------------------------------------------------
	initial forever #25 clk_i = ~clk_i;
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// entered just after a rising edge; holds the request until ack is seen
	task automatic wb(input logic w, input logic [8:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int n;
		n = 0;
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= {23'h0, a};
		dat_i <= d;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack_o !== 1'b1 && n < 20);
		q = dat_o;
		chk({31'h0, ack_o}, 32'h1);
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		we_i <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic wr(input logic [8:0] a, input logic [31:0] d);
		logic [31:0] q;
		wb(1'b1, a, d, q);
	endtask
	task automatic rd(input logic [8:0] a, input logic [31:0] exp);
		logic [31:0] q;
		wb(1'b0, a, 32'h0, q);
		chk(q, exp);
	endtask
	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// ------------------------------------------------------------
	// tests
	// ------------------------------------------------------------
	initial begin
		#200000;
		error_cnt++;
		stop_test();
	end
	initial begin
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		rd(irq_regs_pkg::pending_off, 32'h0);
		rd(irq_regs_pkg::enabled_off, 32'h0);
		rd(irq_regs_pkg::core_line_off, 32'h0);
		rd(irq_regs_pkg::debug_off, 32'h0);
		rd(9'h118, 32'h0);
		$display("test reset done");
		wr(irq_regs_pkg::enable_cmd_off, 32'h8000_0005);
		rd(irq_regs_pkg::enabled_off, 32'h8000_0005);
		wr(irq_regs_pkg::disable_cmd_off, 32'h0000_0004);
		rd(irq_regs_pkg::enabled_off, 32'h8000_0001);
		wr(irq_regs_pkg::enable_cmd_off, 32'h0000_0004);
		wr(irq_regs_pkg::enabled_off, 32'hffff_ffff);
		rd(irq_regs_pkg::enabled_off, 32'h8000_0005);
		$display("test mask done");
		wr(irq_regs_pkg::set_cmd_off, 32'h0000_0103);
		rd(irq_regs_pkg::pending_off, 32'h0000_0103);
		wr(irq_regs_pkg::clear_cmd_off, 32'h0000_0001);
		rd(irq_regs_pkg::pending_off, 32'h0000_0102);
		source_level_i <= 32'h0000_0010;
		wr(irq_regs_pkg::clear_cmd_off, 32'h0000_0010);
		rd(irq_regs_pkg::pending_off, 32'h0000_0112);
		source_level_i <= 32'h0;
		wr(irq_regs_pkg::clear_cmd_off, 32'hffff_ffff);
		rd(irq_regs_pkg::pending_off, 32'h0);
		$display("test pending done");
		current_source_number_i <= 5'h13;
		current_vector_i <= 32'habcd_0100;
		fast_vector_i <= 32'h0000_f00c;
		rd(irq_regs_pkg::source_number_off, 32'h0000_0013);
		wr(irq_regs_pkg::spurious_off, 32'h1234_5678);
		rd(irq_regs_pkg::normal_vector_off, 32'h1234_5678);
		rd(irq_regs_pkg::fast_vector_off, 32'h1234_5678);
		current_valid_i <= 1'b1;
		fast_current_i <= 1'b1;
		rd(irq_regs_pkg::normal_vector_off, 32'habcd_0100);
		rd(irq_regs_pkg::fast_vector_off, 32'h0000_f00c);
		$display("test vectors done");
		// lines lag the requests by one flop, so let one edge pass before reading
		normal_request_i <= 1'b1;
		@(posedge clk_i);
		rd(irq_regs_pkg::core_line_off, 32'h2);
		fast_request_i <= 1'b1;
		@(posedge clk_i);
		rd(irq_regs_pkg::core_line_off, 32'h3);
		chk({30'h0, fseen, nseen}, 32'h3);
		wr(irq_regs_pkg::debug_off, 32'h2);
		rd(irq_regs_pkg::core_line_off, 32'h0);
		chk({30'h0, fseen, nseen}, 32'h0);
		wr(irq_regs_pkg::debug_off, 32'h1);
		chk({31'h0, protection_select_o}, 32'h1);
		rd(irq_regs_pkg::core_line_off, 32'h3);
		normal_request_i <= 1'b0;
		fast_request_i <= 1'b0;
		$display("test lines done");
		wr(irq_regs_pkg::fast_en_cmd_off, 32'hffff_ffff);
		rd(irq_regs_pkg::fast_status_off, 32'hffff_fffe);
		wr(irq_regs_pkg::fast_dis_cmd_off, 32'h0000_0006);
		rd(irq_regs_pkg::fast_status_off, 32'hffff_fff8);
		$display("test fast done");
		wr(irq_regs_pkg::evt_clear_off, 32'h7);
		wr(irq_regs_pkg::evt_enable_off, 32'h1);
		chk({31'h0, irq_o}, 32'h0);
		wr(irq_regs_pkg::end_service_off, 32'hdead_beef);
		rd(irq_regs_pkg::evt_status_off, 32'h1);
		chk({31'h0, irq_o}, 32'h1);
		wr(irq_regs_pkg::evt_enable_off, 32'h0);
		chk({31'h0, irq_o}, 32'h0);
		wr(irq_regs_pkg::evt_enable_off, 32'h1);
		chk({31'h0, irq_o}, 32'h1);
		wr(irq_regs_pkg::evt_clear_off, 32'h1);
		chk({31'h0, irq_o}, 32'h0);
		rd(irq_regs_pkg::evt_status_off, 32'h0);
		$display("test events done");
		stop_test();
	end
endmodule
